// ### design/safety_relay_output_control.sv
// Safety relay output control with classic Wishbone configuration slave
`timescale 1ns/1ps
module safety_relay_output_control
  import safety_relay_pkg::*;
#(
  parameter int unsigned INIT_LEN     = INIT_CYCLES,
  parameter int unsigned FB_TIMEOUT   = FB_TIMEOUT_CYCLES,
  parameter int unsigned DELAY_STEP   = DELAY_STEP_CYCLES,
  parameter int unsigned MARGIN       = MARGIN_CYCLES,
  parameter int unsigned FLASH_LEN    = FLASH_CYCLES,
  parameter int unsigned OFFTEST_GAP  = OFFTEST_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        input_ch1_in,
  input  wire logic        input_ch2_in,
  input  wire logic        start_button_in,
  input  wire logic        feedback_input_a_in,
  input  wire logic        feedback_input_b_in,
  input  wire logic        or_logic_input_in,
  input  wire logic        and_logic_input_in,
  input  wire logic        earth_fault_in,
  input  wire logic        output_readback_in,
  output logic             test_pulse_1_out,
  output logic             test_pulse_2_out,
  output logic             first_safety_output_out,
  output logic             delayed_safety_output_out,
  output logic             auxiliary_output_pin_out,
  output logic             power_indicator_out,
  output logic             channel_one_indicator_out,
  output logic             channel_two_indicator_out,
  output logic             ready_out
);

  // Refuse counts that the timers and the off-test spacing cannot serve
  if (INIT_LEN < 2 || FB_TIMEOUT < 1 || DELAY_STEP < 1 || FLASH_LEN < 1 || OFFTEST_GAP < 8) begin : g_bad_params
    $error("safety_relay_output_control: counts too small");
  end

  relay_state_t state_q;
  relay_cfg_t   cfg_q;
  relay_cfg_t   cfg_live_q;
  relay_out_t   out_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic [CNT_W-1:0] dly_cnt_q;
  logic [CNT_W-1:0] fb_cnt_q;
  logic [CNT_W-1:0] flash_cnt_q;
  logic [CNT_W-1:0] ot_cnt_q;
  logic        dly_run_q;
  logic        fb_watch_q;
  logic        fb_lock_q;
  logic        fb_pre_err_q;
  logic        short_err_q;
  logic        earth_err_q;
  logic        ot_err_q;
  logic        start_seen_q;
  logic        opened_seen_q;
  logic        flash_q;
  logic        tp_phase_q;
  logic        ot_active_q;
  logic        ot_check_q;
  logic        dly_hold;
  logic        in_closed;
  logic        fb_closed;
  logic        fault;
  logic [CNT_W-1:0] delay_cycles;

  // Delay time from a select code, in cycles
  function automatic logic [CNT_W-1:0] delay_of(input logic [3:0] sel);
    delay_of = CNT_W'(sel) * CNT_W'(DELAY_STEP);
  endfunction

  assign in_closed = ((cfg_q.dual ? (input_ch1_in & input_ch2_in) : input_ch1_in)
                      | or_logic_input_in) & and_logic_input_in;
  assign fb_closed = feedback_input_a_in & feedback_input_b_in;
  assign fault     = fb_lock_q | short_err_q | earth_err_q | ot_err_q;
  assign delay_cycles = delay_of(cfg_q.delay_sel);
  // Covers the opening edge too, so the delayed channel never dips before its timer starts
  assign dly_hold = ((state_q == ST_ON) && !in_closed && delay_cycles != '0) ||
                    (dly_run_q && dly_cnt_q + 1'b1 < delay_cycles);

  // Wishbone slave; single-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
      cfg_live_q <= relay_cfg_t'(CFG_RESET[8:0]);
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
      wb_dat_out <= 32'h0000_0000;
      if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
        if (wb_we_in && wb_adr_in == CFG_ADDR) begin
          if (wb_sel_in[0]) begin
            cfg_live_q.dual         <= wb_dat_in[CFG_DUAL_BIT];
            cfg_live_q.short_det    <= wb_dat_in[CFG_SHORT_BIT];
            cfg_live_q.monitored    <= wb_dat_in[CFG_MON_BIT];
            cfg_live_q.startup_test <= wb_dat_in[CFG_SUTEST_BIT];
            cfg_live_q.out1_delayed <= wb_dat_in[CFG_OUT1DLY_BIT];
          end
          if (wb_sel_in[1])
            cfg_live_q.delay_sel <= wb_dat_in[CFG_DELAY_LSB +: CFG_DELAY_W];
        end else if (!wb_we_in) begin
          case (wb_adr_in)
            CFG_ADDR: begin
              wb_dat_out[CFG_DUAL_BIT]    <= cfg_live_q.dual;
              wb_dat_out[CFG_SHORT_BIT]   <= cfg_live_q.short_det;
              wb_dat_out[CFG_MON_BIT]     <= cfg_live_q.monitored;
              wb_dat_out[CFG_SUTEST_BIT]  <= cfg_live_q.startup_test;
              wb_dat_out[CFG_OUT1DLY_BIT] <= cfg_live_q.out1_delayed;
              wb_dat_out[CFG_DELAY_LSB +: CFG_DELAY_W] <= cfg_live_q.delay_sel;
            end
            STATUS_ADDR: begin
              wb_dat_out[5:0]  <= state_q;
              wb_dat_out[8]    <= fb_pre_err_q;
              wb_dat_out[9]    <= fb_lock_q;
              wb_dat_out[10]   <= short_err_q;
              wb_dat_out[11]   <= earth_err_q;
              wb_dat_out[12]   <= ot_err_q;
              wb_dat_out[13]   <= in_closed;
              wb_dat_out[14]   <= fb_closed;
            end
            default: wb_dat_out <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      cfg_q <= relay_cfg_t'(CFG_RESET[8:0]);
    else if (state_q == ST_INIT)
      cfg_q <= cfg_live_q;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in)
      init_cnt_q <= '0;
    else if (state_q == ST_INIT)
      init_cnt_q <= init_cnt_q + 1'b1;
  end

  // Fault latches; earth and short faults need reset, like the others
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      earth_err_q <= 1'b0;
      short_err_q <= 1'b0;
    end else if (state_q != ST_INIT) begin
      if (earth_fault_in)
        earth_err_q <= 1'b1;
      if (cfg_q.dual && cfg_q.short_det && (input_ch1_in ^ tp_phase_q) == (input_ch2_in ^ ~tp_phase_q) &&
          input_ch1_in != input_ch2_in)
        short_err_q <= 1'b1;
    end
  end

  // test pulses alternate, one channel high at a time, while short detection is on; both held high when it is off
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tp_phase_q       <= 1'b0;
      test_pulse_1_out <= 1'b0;
      test_pulse_2_out <= 1'b0;
    end else begin
      tp_phase_q       <= ~tp_phase_q;
      test_pulse_1_out <= cfg_q.short_det ? ~tp_phase_q : 1'b1;
      test_pulse_2_out <= cfg_q.short_det ? tp_phase_q : 1'b1;
    end
  end

  // periodic off-test on the safety outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ot_cnt_q    <= '0;
      ot_active_q <= 1'b0;
      ot_check_q  <= 1'b0;
      ot_err_q    <= 1'b0;
    end else if (state_q == ST_ON) begin
      ot_cnt_q <= (ot_cnt_q >= CNT_W'(OFFTEST_GAP)) ? '0 : ot_cnt_q + 1'b1;
      ot_active_q <= (ot_cnt_q == CNT_W'(OFFTEST_GAP - 2));
      // Readback judged in the cycle the output register has actually dropped
      ot_check_q  <= ot_active_q;
      if (ot_check_q && output_readback_in)
        ot_err_q <= 1'b1;
    end else begin
      ot_cnt_q    <= '0;
      ot_active_q <= 1'b0;
      ot_check_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      start_seen_q  <= 1'b0;
      opened_seen_q <= 1'b0;
    end else begin
      if (state_q != ST_START)
        start_seen_q <= 1'b0;
      else if (start_button_in)
        start_seen_q <= 1'b1;
      if (state_q != ST_INIT && !in_closed)
        opened_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fb_watch_q <= 1'b0;
      fb_cnt_q   <= '0;
      fb_lock_q  <= 1'b0;
    end else begin
      if (out_q.delayed_safety_output && !dly_run_q && state_q == ST_ON && !in_closed && delay_cycles == '0) begin
        fb_watch_q <= 1'b1;
        fb_cnt_q   <= '0;
      end else if (dly_run_q && dly_cnt_q + 1'b1 >= delay_cycles) begin
        fb_watch_q <= 1'b1;
        fb_cnt_q   <= '0;
      end else if (fb_watch_q) begin
        if (fb_closed)
          fb_watch_q <= 1'b0;
        else if (fb_cnt_q + 1'b1 >= CNT_W'(FB_TIMEOUT)) begin
          fb_lock_q  <= 1'b1;
          fb_watch_q <= 1'b0;
        end else
          fb_cnt_q <= fb_cnt_q + 1'b1;
      end
    end
  end

  // worst-case off bound is held by the count itself
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dly_run_q <= 1'b0;
      dly_cnt_q <= '0;
    end else if (state_q == ST_ON && !in_closed && !dly_run_q && delay_cycles != '0) begin
      dly_run_q <= 1'b1;
      dly_cnt_q <= '0;
    end else if (dly_run_q) begin
      if (dly_cnt_q + 1'b1 >= delay_cycles)
        dly_run_q <= 1'b0;
      dly_cnt_q <= dly_cnt_q + 1'b1;
    end
  end

  // Main sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q      <= ST_INIT;
      fb_pre_err_q <= 1'b0;
    end else begin
      case (state_q)
        ST_INIT:
          if (init_cnt_q >= CNT_W'(INIT_LEN - 1))
            state_q <= ST_IDLE;
        ST_IDLE:
          if (fault)
            state_q <= ST_LOCK;
          else if (in_closed && !dly_run_q && !fb_watch_q &&
                   (!cfg_q.startup_test || opened_seen_q))
            state_q <= ST_START;
        ST_START:
          if (fault)
            state_q <= ST_LOCK;
          else if (!in_closed)
            state_q <= ST_IDLE;
          else if (!cfg_q.monitored || (start_seen_q && !start_button_in)) begin
            if (!fb_closed) begin
              state_q      <= ST_FBERR;
              fb_pre_err_q <= 1'b1;
            end else
              state_q <= ST_ON;
          end
        ST_ON:
          if (fault || !in_closed)
            state_q <= fault ? ST_LOCK : ST_IDLE;
        // need loops closed and input reset
        ST_FBERR:
          if (fault)
            state_q <= ST_LOCK;
          else if (fb_closed && !in_closed) begin
            fb_pre_err_q <= 1'b0;
            state_q      <= ST_IDLE;
          end
        ST_LOCK:
          state_q <= ST_LOCK;
        default:
          state_q <= ST_LOCK;
      endcase
    end
  end

  // Alternate flash timebase for the error display
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q >= CNT_W'(FLASH_LEN - 1)) begin
      flash_cnt_q <= '0;
      flash_q     <= ~flash_q;
    end else
      flash_cnt_q <= flash_cnt_q + 1'b1;
  end

  // Outputs; the delayed channel holds through the running delay
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      out_q     <= '0;
      ready_out <= 1'b0;
    end else begin
      out_q.power_indicator <= (state_q != ST_INIT);
      ready_out <= (state_q != ST_INIT) && fb_closed && !fault;
      out_q.auxiliary_output_pin <= (state_q == ST_ON) && in_closed;
      out_q.first_safety_output  <= ((state_q == ST_ON) && in_closed && !ot_active_q) ||
                                    (cfg_q.out1_delayed && dly_hold);
      out_q.delayed_safety_output <= ((state_q == ST_ON) && in_closed && !ot_active_q) || dly_hold;
      case (state_q)
        ST_FBERR: begin
          out_q.channel_one_indicator <= flash_q;
          out_q.channel_two_indicator <= ~flash_q;
        end
        ST_LOCK: begin
          out_q.channel_one_indicator <= flash_q;
          out_q.channel_two_indicator <= flash_q;
        end
        default: begin
          out_q.channel_one_indicator <= (state_q == ST_ON) && in_closed;
          out_q.channel_two_indicator <= ((state_q == ST_ON) && in_closed) || dly_hold;
        end
      endcase
    end
  end

  assign first_safety_output_out   = out_q.first_safety_output;
  assign delayed_safety_output_out = out_q.delayed_safety_output;
  assign auxiliary_output_pin_out  = out_q.auxiliary_output_pin;
  assign power_indicator_out       = out_q.power_indicator;
  assign channel_one_indicator_out = out_q.channel_one_indicator;
  assign channel_two_indicator_out = out_q.channel_two_indicator;

endmodule

// ### include/safety_relay_pkg.sv
// Package of constants and types for the safety relay output control
package safety_relay_pkg;

  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned INIT_TIME_US      = 100;
  localparam int unsigned INIT_CYCLES       = (INIT_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned FB_TIMEOUT_MS     = 150;
  localparam int unsigned FB_TIMEOUT_CYCLES = FB_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned MARGIN_MS         = 40;
  localparam int unsigned MARGIN_CYCLES     = MARGIN_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_MS          = 250;
  localparam int unsigned FLASH_CYCLES      = FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned OFFTEST_MS        = 1000;
  localparam int unsigned OFFTEST_CYCLES    = OFFTEST_MS * (CLK_HZ / 1000);
  localparam int unsigned OFFTEST_US        = 1;
  localparam int unsigned OFFTEST_LEN       = (OFFTEST_US * CLK_HZ) / 1_000_000;
  localparam int unsigned DELAY_STEP_MS     = 500;
  localparam int unsigned DELAY_STEP_CYCLES = DELAY_STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W             = 32;

  // Register map, all offsets are byte addresses
  localparam logic [7:0] CFG_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CLEAR_ADDR  = 8'h08;

  // Configuration field positions
  localparam int unsigned CFG_DUAL_BIT    = 0;
  localparam int unsigned CFG_SHORT_BIT   = 1;
  localparam int unsigned CFG_MON_BIT     = 2;
  localparam int unsigned CFG_SUTEST_BIT  = 3;
  localparam int unsigned CFG_OUT1DLY_BIT = 4;
  localparam int unsigned CFG_DELAY_LSB   = 8;
  localparam int unsigned CFG_DELAY_W     = 4;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

  typedef enum logic [5:0] {
    ST_INIT   = 6'b000001,
    ST_IDLE   = 6'b000010,
    ST_START  = 6'b000100,
    ST_ON     = 6'b001000,
    ST_FBERR  = 6'b010000,
    ST_LOCK   = 6'b100000
  } relay_state_t;

  typedef struct packed {
    logic first_safety_output;
    logic delayed_safety_output;
    logic auxiliary_output_pin;
    logic power_indicator;
    logic channel_one_indicator;
    logic channel_two_indicator;
  } relay_out_t;

  typedef struct packed {
    logic        dual;
    logic        short_det;
    logic        monitored;
    logic        startup_test;
    logic        out1_delayed;
    logic [3:0]  delay_sel;
  } relay_cfg_t;

endpackage

// ### verif/safety_relay_chk.sv
// Concurrent checks on the safety relay output control ports
`timescale 1ns/1ps
module safety_relay_chk
  import safety_relay_pkg::*;
#(
  parameter int unsigned INIT_LEN   = 20,
  parameter int unsigned FB_TIMEOUT = 50,
  parameter int unsigned DELAY_STEP = 10,
  parameter int unsigned MARGIN     = 4
) (
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        input_ch1_in,
  input wire logic        or_logic_input_in,
  input wire logic        feedback_input_a_in,
  input wire logic        feedback_input_b_in,
  input wire logic        first_safety_output_out,
  input wire logic        delayed_safety_output_out,
  input wire logic        auxiliary_output_pin_out,
  input wire logic        power_indicator_out,
  input wire logic        channel_one_indicator_out,
  input wire logic        channel_two_indicator_out,
  input wire logic        ready_out
);
  logic [31:0] age_q;
  logic [31:0] off_q;
  logic [31:0] fbw_q;
  logic [3:0]  dly_q;
  logic        armed_q;
  logic        lock_q;
  logic        fb_ok;

  assign fb_ok = feedback_input_a_in && feedback_input_b_in;

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) age_q <= '0;
    else if (age_q < 32'h0000_ffff) age_q <= age_q + 32'h1;
  end

  // Delay shadow follows writes only while initialising, as the device does
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) dly_q <= '0;
    else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in == CFG_ADDR && wb_sel_in[1]
             && !power_indicator_out) dly_q <= wb_dat_in[11:8];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) off_q <= '0;
    else if (delayed_safety_output_out && !auxiliary_output_pin_out) off_q <= off_q + 32'h1;
    else off_q <= '0;
  end

  // Slack of two cycles covers the registered feedback path
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      armed_q <= 1'b0;
      fbw_q   <= '0;
      lock_q  <= 1'b0;
    end else begin
      if ($fell(auxiliary_output_pin_out)) armed_q <= 1'b1;
      else if (fb_ok) armed_q <= 1'b0;
      fbw_q <= armed_q && !fb_ok ? fbw_q + 32'h1 : '0;
      if (fbw_q > FB_TIMEOUT + 2) lock_q <= 1'b1;
    end
  end

  AST_POWER_AFTER_INIT: assert property (power_indicator_out |-> age_q >= INIT_LEN)
    else $error("power lamp lit before initialisation ended");
  AST_READY_FB: assert property (ready_out |-> $past(fb_ok))
    else $error("ready shown with a feedback loop open");
  AST_ON_ALL: assert property ($rose(auxiliary_output_pin_out) |-> first_safety_output_out
    && delayed_safety_output_out && channel_one_indicator_out && channel_two_indicator_out)
    else $error("switch-on did not raise all outputs and lamps");
  AST_OPEN_DROP: assert property ($fell(input_ch1_in) && !or_logic_input_in && auxiliary_output_pin_out
    |=> !auxiliary_output_pin_out && !channel_one_indicator_out)
    else $error("auxiliary output or lamp one stayed on after input opened");
  AST_CH2_AFTER: assert property ($fell(channel_two_indicator_out) |-> !delayed_safety_output_out)
    else $error("lamp two went out while delayed output high");
  AST_DELAY_BOUND: assert property (off_q <= dly_q * DELAY_STEP + MARGIN + dly_q * DELAY_STEP / 10)
    else $error("delayed output exceeded its worst-case hold");
  AST_PRECHECK: assert property ($rose(auxiliary_output_pin_out) |-> $past(fb_ok) && $past(fb_ok, 2))
    else $error("outputs switched on with feedback open");
  AST_LOCK: assert property (lock_q |-> !auxiliary_output_pin_out)
    else $error("outputs enabled after switch-off feedback timeout");
  AST_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acknowledged in one cycle");
endmodule

bind safety_relay_output_control safety_relay_chk #(.INIT_LEN(INIT_LEN), .FB_TIMEOUT(FB_TIMEOUT),
  .DELAY_STEP(DELAY_STEP), .MARGIN(MARGIN)) safety_relay_chk_i (.clk_sys_in, .rst_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .input_ch1_in, .or_logic_input_in,
  .feedback_input_a_in, .feedback_input_b_in, .first_safety_output_out, .delayed_safety_output_out,
  .auxiliary_output_pin_out, .power_indicator_out, .channel_one_indicator_out, .channel_two_indicator_out,
  .ready_out);

// ### verif/contactor_model.sv
// External contactor pair with feedback contacts and output readback
`timescale 1ns/1ps
module contactor_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       drive_a_in,
  input  wire logic       drive_b_in,
  input  wire logic [7:0] release_len_in,
  input  wire logic       stuck_open_in,
  output logic            fb_a_out,
  output logic            fb_b_out,
  output logic            readback_out
);
  logic [7:0] hold_q;
  logic       energised;

  // Armature drops out only after the release time, so one-cycle off-tests do not reach the feedback
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) hold_q <= '0;
    else if (drive_a_in || drive_b_in) hold_q <= release_len_in;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
  end

  assign energised = drive_a_in || drive_b_in || hold_q != 8'h00;
  assign fb_a_out = !energised && !stuck_open_in;
  assign fb_b_out = !energised && !stuck_open_in;
  assign readback_out = drive_a_in || drive_b_in;
endmodule

// ### verif/safety_relay_output_control_tb.sv
// Self-checking bench for the safety relay output control
`timescale 1ns/1ps
module safety_relay_output_control_tb;
  import safety_relay_pkg::*;
  logic        clk_sys_in, rst_in, wb_cyc, wb_stb, wb_we, ch1, ch2, start_btn, or_in, and_in, earth, stuck;
  logic        fb_a, fb_b, rb, ack, first_o, dly_o, aux_o, pwr_o, ch1_o, ch2_o, rdy_o, tp1, tp2;
  logic [7:0]  wb_adr, rel_len;
  logic [3:0]  wb_sel, wsel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  int          n_fail, n_tests, cyc_cnt, waited;

  safety_relay_output_control #(.INIT_LEN(20), .FB_TIMEOUT(50), .DELAY_STEP(10), .MARGIN(4), .FLASH_LEN(4),
    .OFFTEST_GAP(64)) safety_relay_output_control_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(ack), .input_ch1_in(ch1), .input_ch2_in(ch2),
    .start_button_in(start_btn), .feedback_input_a_in(fb_a), .feedback_input_b_in(fb_b),
    .or_logic_input_in(or_in), .and_logic_input_in(and_in), .earth_fault_in(earth), .output_readback_in(rb),
    .test_pulse_1_out(tp1), .test_pulse_2_out(tp2), .first_safety_output_out(first_o),
    .delayed_safety_output_out(dly_o), .auxiliary_output_pin_out(aux_o), .power_indicator_out(pwr_o),
    .channel_one_indicator_out(ch1_o), .channel_two_indicator_out(ch2_o), .ready_out(rdy_o));

  contactor_model contactor_model_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .drive_a_in(first_o),
    .drive_b_in(dly_o), .release_len_in(rel_len), .stuck_open_in(stuck), .fb_a_out(fb_a), .fb_b_out(fb_b),
    .readback_out(rb));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task report_and_stop;
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // Read data is taken at the same edge that sees ack
  task wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, a, d, wsel};
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (ack !== 1'b1 && k < 50);
    chk("ack", 1, ack);
    rd = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask

  function logic sig(input int w);
    case (w)
      0: return aux_o;
      1: return pwr_o;
      2: return dly_o;
      default: return first_o;
    endcase
  endfunction

  task wait_on(input int w, input logic v, input int lim);
    waited = 0;
    @(negedge clk_sys_in);
    while (sig(w) !== v && waited < lim) begin
      @(negedge clk_sys_in);
      waited++;
    end
    chk("wait", {31'h0, v}, {31'h0, sig(w)});
    // Hand back on a rising edge so the next stimulus lands there
    @(posedge clk_sys_in);
  endtask

  task inp(input logic v);
    @(posedge clk_sys_in);
    ch1 <= v;
    ch2 <= v;
  endtask

  // Configuration must land while the device is still initialising
  task boot(input logic [31:0] cfg);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    tick(10);
    rst_in <= 1'b0;
    wb_rw(1'b1, CFG_ADDR, cfg);
    chk("rdy_init", 0, rdy_o);
    wait_on(1, 1'b1, 40);
  endtask

  task t_auto_delay;
    int drops;
    boot(32'h0000_0300);
    chk("ready", 1, rdy_o);
    chk("tp_off", 2'b11, {tp1, tp2});
    wsel = 4'h1;
    wb_rw(1'b1, CFG_ADDR, 32'h0000_0f04);
    wsel = 4'hf;
    wb_rw(1'b0, CFG_ADDR, 32'h0);
    chk("cfg", 32'h0000_0304, rd);
    wb_rw(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
    inp(1'b1);
    wait_on(0, 1'b1, 10);
    chk("on", 4'hf, {first_o, dly_o, ch1_o, ch2_o});
    drops = 0;
    repeat (70) begin
      @(negedge clk_sys_in);
      if (!first_o && aux_o) drops++;
    end
    chk("offtest", 1, drops > 0);
    inp(1'b0);
    tick(1);
    @(negedge clk_sys_in);
    chk("drop", 4'h2, {aux_o, first_o, ch1_o, dly_o, 1'b0});
    wait_on(2, 1'b0, 60);
    chk("delay", 1, waited >= 26 && waited <= 31);
    tick(1);
    chk("ch2_off", 0, ch2_o);
  endtask

  task t_monitored;
    boot(32'h0000_0004);
    inp(1'b1);
    tick(20);
    chk("no_auto", 0, aux_o);
    start_btn <= 1'b1;
    tick(5);
    chk("pressed", 0, aux_o);
    start_btn <= 1'b0;
    wait_on(0, 1'b1, 20);
    inp(1'b0);
  endtask

  task t_startup;
    inp(1'b1);
    boot(32'h0000_0008);
    tick(20);
    chk("startup", 0, aux_o);
    inp(1'b0);
    tick(5);
    inp(1'b1);
    wait_on(0, 1'b1, 20);
    inp(1'b0);
  endtask

  task t_pre_err;
    int alt;
    boot(32'h0);
    stuck <= 1'b1;
    inp(1'b1);
    tick(20);
    chk("pre_err", 2'b00, {aux_o, rdy_o});
    alt = 0;
    repeat (8) begin
      @(negedge clk_sys_in);
      if (ch1_o !== ch2_o) alt++;
    end
    chk("flash", 8, alt);
    stuck <= 1'b0;
    tick(20);
    chk("no_reen", 0, aux_o);
    inp(1'b0);
    tick(5);
    inp(1'b1);
    wait_on(0, 1'b1, 20);
    inp(1'b0);
  endtask

  task t_slow_fb;
    boot(32'h0);
    rel_len <= 8'd80;
    inp(1'b1);
    wait_on(0, 1'b1, 10);
    inp(1'b0);
    tick(130);
    inp(1'b1);
    tick(20);
    chk("locked", 0, aux_o);
    wb_rw(1'b0, STATUS_ADDR, 32'h0);
    chk("lock_bit", 1, rd[9]);
    inp(1'b0);
    tick(5);
    inp(1'b1);
    tick(20);
    chk("still", 0, aux_o);
    rel_len <= 8'd3;
    inp(1'b0);
  endtask

  task t_dual_logic;
    boot(32'h0000_0001);
    inp(1'b1);
    wait_on(0, 1'b1, 20);
    ch2 <= 1'b0;
    wait_on(0, 1'b0, 3);
    inp(1'b0);
    tick(10);
    inp(1'b1);
    wait_on(0, 1'b1, 20);
    and_in <= 1'b0;
    wait_on(0, 1'b0, 3);
    and_in <= 1'b1;
    tick(10);
    wait_on(0, 1'b1, 20);
    or_in <= 1'b1;
    inp(1'b0);
    tick(5);
    chk("or_hold", 1, aux_o);
    or_in <= 1'b0;
    wait_on(0, 1'b0, 3);
  endtask

  task t_out1_dly_earth;
    boot(32'h0000_0210);
    inp(1'b1);
    wait_on(0, 1'b1, 10);
    inp(1'b0);
    tick(3);
    chk("out1_dly", 2'b10, {first_o, aux_o});
    wait_on(3, 1'b0, 40);
    boot(32'h0000_0003);
    inp(1'b1);
    wait_on(0, 1'b1, 10);
    @(negedge clk_sys_in);
    chk("tp_alt", 1, tp1 ^ tp2);
    @(posedge clk_sys_in);
    earth <= 1'b1;
    wait_on(0, 1'b0, 5);
    earth <= 1'b0;
    ch2 <= 1'b0;
    wb_rw(1'b0, STATUS_ADDR, 32'h0);
    chk("earth_bit", 1, rd[11]);
    chk("short_bit", 1, rd[10]);
    inp(1'b0);
  endtask

  always @(posedge clk_sys_in) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      report_and_stop;
    end
  end

  initial begin
    {rst_in, wb_cyc, wb_stb, wb_we, ch1, ch2, start_btn, or_in, earth, stuck} = 10'b10_0000_0000;
    {wb_adr, wb_sel, wb_wdat} = '0;
    and_in = 1'b1;
    rel_len = 8'd3;
    wsel = 4'hf;
    n_fail = 0;
    n_tests = 0;
    cyc_cnt = 0;
    t_auto_delay;
    t_monitored;
    t_startup;
    t_pre_err;
    t_slow_fb;
    t_dual_logic;
    t_out1_dly_earth;
    report_and_stop;
  end
endmodule
